// ==== design/ros_relay_select.v ====
// relay output function selector for a motor drive
// Behaviour
// R1: select setting 0..9, default 1
// R2: 0 asserts while output stage running
// R3: 1 asserts while powered and healthy and not tripped
// R4: 2 asserts while output freq equals setpoint
// R5: 3 asserts while drive tripped
// R6: 4 asserts when freq at/above threshold
// R7: 5 asserts when current at/above threshold
// R8: 6 asserts when freq below threshold
// R9: 7 asserts when current below threshold
// R10: 8 asserts when analog input 2 exceeds threshold
// R11: 9 asserts when ready and no trip
// R12: threshold 0.0..200.0 percent, default 100.0
// R13: evaluated each cycle, registered, reset deasserts
`timescale 1ns/1ps
`default_nettype none
`include "ros_defines.vh"

module ros_relay_select #(
  parameter W = `ROS_THR_W
) (
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire                  cfg_we,
  input  wire [`ROS_SEL_W-1:0] cfg_sel,
  input  wire [`ROS_THR_W-1:0] cfg_thr,
  input  wire                  st_running,
  input  wire                  st_healthy,
  input  wire                  st_tripped,
  input  wire                  st_ready,
  input  wire [W-1:0]          out_freq,
  input  wire [W-1:0]          set_freq,
  input  wire [W-1:0]          motor_curr,
  input  wire [W-1:0]          ain2_level,
  output reg                   relay_ff,
  output reg  [`ROS_SEL_W-1:0] sel_ff,
  output reg  [`ROS_THR_W-1:0] thr_ff
);

  // ************************************************************
  // settings
  // ************************************************************
  reg  [`ROS_SEL_W-1:0] nxt_sel;
  reg  [`ROS_THR_W-1:0] nxt_thr;
  reg                   nxt_relay;
  wire [W-1:0]          thr_w;
  wire                  f_ge;
  wire                  f_lt;
  wire                  c_ge;
  wire                  c_lt;
  wire                  a_gt;

  // out-of-range writes keep the old value rather than clamping
  always @* begin
    nxt_sel = sel_ff;
    nxt_thr = thr_ff;
    if (cfg_we) begin
      if (cfg_sel <= `ROS_SEL_MAX) begin
        nxt_sel = cfg_sel; // [R1]
      end
      if (cfg_thr <= `ROS_THR_MAX) begin
        nxt_thr = cfg_thr; // [R12]
      end
    end
  end

  // ************************************************************
  // comparators
  // ************************************************************
  assign thr_w = thr_ff[W-1:0];

  ros_compare #(.W(W)) u_freq (
    .meas (out_freq),
    .thr  (thr_w),
    .ge   (f_ge),
    .gt   (),
    .lt   (f_lt)
  );

  ros_compare #(.W(W)) u_curr (
    .meas (motor_curr),
    .thr  (thr_w),
    .ge   (c_ge),
    .gt   (),
    .lt   (c_lt)
  );

  ros_compare #(.W(W)) u_ain2 (
    .meas (ain2_level),
    .thr  (thr_w),
    .ge   (),
    .gt   (a_gt),
    .lt   ()
  );

  // ************************************************************
  // source select
  // ************************************************************
  // threshold only matters for codes 4..8
  always @* begin
    case (sel_ff)
      `ROS_SEL_RUNNING:  nxt_relay = st_running;                // [R2]
      `ROS_SEL_HEALTHY:  nxt_relay = st_healthy & ~st_tripped;  // [R3]
      `ROS_SEL_AT_SPEED: nxt_relay = (out_freq == set_freq);    // [R4]
      `ROS_SEL_TRIPPED:  nxt_relay = st_tripped;                // [R5]
      `ROS_SEL_FREQ_GE:  nxt_relay = f_ge;                      // [R6] [R12]
      `ROS_SEL_CURR_GE:  nxt_relay = c_ge;                      // [R7]
      `ROS_SEL_FREQ_LT:  nxt_relay = f_lt;                      // [R8]
      `ROS_SEL_CURR_LT:  nxt_relay = c_lt;                      // [R9]
      `ROS_SEL_AIN2_GT:  nxt_relay = a_gt;                      // [R10]
      `ROS_SEL_READY:    nxt_relay = st_ready & ~st_tripped;    // [R11]
      default:           nxt_relay = 1'b0;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // status inputs come from same-clock logic, no synchroniser
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      relay_ff <= 1'b0;            // [R13]
      sel_ff   <= `ROS_SEL_RESET;  // [R1]
      thr_ff   <= `ROS_THR_RESET;  // [R12]
    end else begin
      relay_ff <= nxt_relay;       // [R13]
      sel_ff   <= nxt_sel;
      thr_ff   <= nxt_thr;
    end
  end

endmodule // ros_relay_select

`default_nettype wire

// ==== pkg/ros_defines.vh ====
// constants for the relay output selector
`ifndef ROS_DEFINES_VH
`define ROS_DEFINES_VH

// ************************************************************
// function select codes
// ************************************************************
`define ROS_SEL_W          4
`define ROS_SEL_RUNNING    4'h0
`define ROS_SEL_HEALTHY    4'h1
`define ROS_SEL_AT_SPEED   4'h2
`define ROS_SEL_TRIPPED    4'h3
`define ROS_SEL_FREQ_GE    4'h4
`define ROS_SEL_CURR_GE    4'h5
`define ROS_SEL_FREQ_LT    4'h6
`define ROS_SEL_CURR_LT    4'h7
`define ROS_SEL_AIN2_GT    4'h8
`define ROS_SEL_READY      4'h9
`define ROS_SEL_MAX        4'h9
`define ROS_SEL_RESET      4'h1

// ************************************************************
// threshold level, tenths of a percent
// ************************************************************
`define ROS_THR_W          11
`define ROS_THR_MAX        11'h7d0
`define ROS_THR_RESET      11'h3e8

`endif

// ==== design/ros_compare.v ====
// magnitude compare of a percent measurement against the threshold
`timescale 1ns/1ps
`default_nettype none

module ros_compare #(
  parameter W = 11
) (
  input  wire [W-1:0] meas,
  input  wire [W-1:0] thr,
  output wire         ge,
  output wire         gt,
  output wire         lt
);

  // ************************************************************
  // comparisons
  // ************************************************************
  // one comparator per quantity; freq and current ones each serve two selections, ain2 one
  assign ge = (meas >= thr);
  assign gt = (meas > thr);
  assign lt = (meas < thr);

endmodule // ros_compare

`default_nettype wire

// ==== dv/ros_load.sv ====
// relay contact load on the far side of the selector
`timescale 1ns/1ps
`default_nettype none
module ros_load (
  input  wire logic relay_ff,
  output logic      closed
);
  // contact follows the coil; no bounce modelled, so checks stay exact
  assign closed = relay_ff;
endmodule // ros_load
`default_nettype wire

// ==== dv/ros_chk.sv ====
// concurrent checks on the relay output selector ports
`timescale 1ns/1ps
`default_nettype none
module ros_chk (
  input wire logic        sys_clk, sys_rst, cfg_we, st_running, st_tripped, relay_ff,
  input wire logic [3:0]  sel_ff,
  input wire logic [10:0] cfg_thr, out_freq, ain2_level, thr_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // previous edge was out of reset, so past values are live
  logic lv_ff;
  always @(posedge sys_clk) lv_ff <= !sys_rst;
  chk_sel_range: assert property (sel_ff <= 4'h9) else $error("select range");
  chk_run_sel: assert property (lv_ff && $past(sel_ff) == 4'h0
    |-> relay_ff == $past(st_running)) else $error("running");
  chk_trip_sel: assert property (lv_ff && $past(sel_ff) == 4'h3
    |-> relay_ff == $past(st_tripped)) else $error("tripped");
  chk_freq_ge: assert property (lv_ff && $past(sel_ff) == 4'h4
    |-> relay_ff == ($past(out_freq) >= $past(thr_ff))) else $error("freq ge");
  chk_freq_lt: assert property (lv_ff && $past(sel_ff) == 4'h6
    |-> relay_ff == ($past(out_freq) < $past(thr_ff))) else $error("freq lt");
  chk_ain_gt: assert property (lv_ff && $past(sel_ff) == 4'h8
    |-> relay_ff == ($past(ain2_level) > $past(thr_ff))) else $error("ain gt");
  chk_thr_refuse: assert property (cfg_we && cfg_thr > 11'h7d0
    |=> thr_ff == $past(thr_ff)) else $error("thr refuse");
  chk_reset_low: assert property (disable iff (1'b0) sys_rst
    |=> !relay_ff && sel_ff == 4'h1) else $error("reset");
endmodule // ros_chk
bind ros_relay_select ros_chk chk0 (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the relay output selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk, sys_rst, cfg_we, st_running, st_healthy, st_tripped, st_ready;
  logic        relay_ff, closed;
  logic [3:0]  cfg_sel, sel_ff;
  logic [10:0] cfg_thr, out_freq, set_freq, motor_curr, ain2_level, thr_ff;
  int          n_fail, comparisons;
  ros_relay_select uut (.*);
  ros_load load0 (.relay_ff(relay_ff), .closed(closed));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic ck(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one edge for the relay to follow, then judge the contact
  task automatic tick(input logic exp);
    @(posedge sys_clk) #1;
    ck(closed, exp);
  endtask
  task automatic wr(input logic [3:0] s, input logic [10:0] t);
    cfg_sel = s; cfg_thr = t; cfg_we = 1;
    @(posedge sys_clk) #1 cfg_we = 0;
  endtask
  task automatic t_reset;
    sys_rst = 1;
    @(posedge sys_clk) #1 sys_rst = 0;
    ck(sel_ff, 11'h1);
    ck(thr_ff, 11'h3e8);
    ck(relay_ff, 0);
  endtask
  task automatic t_flags;
    wr(4'h0, 11'h3e8); st_running = 1; tick(1);
    st_running = 0; tick(0);
    wr(4'h1, 11'h3e8); st_healthy = 1; tick(1);
    st_tripped = 1; tick(0);
    wr(4'h3, 11'h3e8); tick(1);
    wr(4'h9, 11'h3e8); st_ready = 1; tick(0);
    st_tripped = 0; tick(1);
  endtask
  task automatic t_cmp;
    wr(4'h2, 11'h200); out_freq = 11'h200; set_freq = 11'h200; tick(1);
    set_freq = 11'h201; tick(0);
    wr(4'h4, 11'h200); tick(1);
    out_freq = 11'h1ff; tick(0);
    wr(4'h6, 11'h200); tick(1);
    motor_curr = 11'h200; wr(4'h5, 11'h200); tick(1);
    wr(4'h7, 11'h200); tick(0);
    motor_curr = 11'h1ff; tick(1);
    ain2_level = 11'h200; wr(4'h8, 11'h200); tick(0);
    ain2_level = 11'h201; tick(1);
  endtask
  // out of range fields are dropped, top of range is taken
  task automatic t_range;
    wr(4'ha, 11'h7d1);
    ck(sel_ff, 11'h8);
    ck(thr_ff, 11'h200);
    wr(4'h9, 11'h7d0);
    ck(thr_ff, 11'h7d0);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {sys_rst, cfg_we, st_running, st_healthy, st_tripped, st_ready} = 6'h20;
    {cfg_sel, cfg_thr, out_freq, set_freq, motor_curr, ain2_level} = '0;
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 0;
    t_flags;
    t_cmp;
    t_range;
    t_reset;
    finish_test;
  end
endmodule // tb
`default_nettype wire
